// [inc/lps_consts.svh]
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

// Register byte offsets
`define LPS_OFF_CTRL 8'h00
`define LPS_OFF_ATIME 8'h04
`define LPS_OFF_WTIME 8'h08
`define LPS_OFF_PPULSE 8'h0C
`define LPS_OFF_GAIN 8'h10
`define LPS_OFF_ALS_THR 8'h14
`define LPS_OFF_PROX_THR 8'h18
`define LPS_OFF_PERSIST 8'h1C
`define LPS_OFF_POFFSET 8'h20
`define LPS_OFF_STATUS 8'h24
`define LPS_OFF_CLEAR 8'h28
`define LPS_OFF_ALS_DATA 8'h2C
`define LPS_OFF_PROX_DATA 8'h30

// CTRL field positions
`define LPS_CTRL_POWER_ON 0
`define LPS_CTRL_ALS_EN 1
`define LPS_CTRL_PROX_EN 2
`define LPS_CTRL_WAIT_EN 3
`define LPS_CTRL_ALS_INT_EN 4
`define LPS_CTRL_PROX_INT_EN 5
`define LPS_CTRL_SLEEP_AFTER_INT 6
`define LPS_CTRL_W 7
// WTIME long-wait flag, GAIN low-gain flag, CLEAR bits
`define LPS_WTIME_LONG 8
`define LPS_GAIN_LOW 2
`define LPS_CLEAR_ALS 0
`define LPS_CLEAR_PROX 1

// Reset values
`define LPS_RST_CTRL 7'h00
`define LPS_RST_ATIME 8'hFF
`define LPS_RST_WTIME 8'hFF
`define LPS_RST_PPULSE 8'h01
`define LPS_RST_GAIN 3'h0
`define LPS_RST_THR_LO 16'h0000
`define LPS_RST_THR_HI 16'hFFFF
`define LPS_RST_PERSIST 4'h0
`define LPS_RST_POFFSET 16'h0000

// Timing
`define LPS_CLK_PERIOD_NS 5
`define LPS_PULSE_PERIOD_NS 16000
`define LPS_PULSE_ON_NS 7200
`define LPS_WAIT_STEP_US 2700
`define LPS_WAIT_LONG_MULT 12
`define LPS_PULSE_PERIOD_CYC (`LPS_PULSE_PERIOD_NS / `LPS_CLK_PERIOD_NS)
`define LPS_PULSE_ON_CYC ((`LPS_PULSE_ON_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)
`define LPS_WAIT_STEP_CYC (`LPS_WAIT_STEP_US * 1000 / `LPS_CLK_PERIOD_NS)

`endif

// [inc/lps_pkg.sv]
package lps_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PROX_PULSE,
      ST_PROX_CONV,
      ST_WAIT,
      ST_ALS_CONV,
      ST_SLEEP
   } lps_state_e;
endpackage : lps_pkg

// [hdl/lps_core.sv]
// What this block does
// - Both light channels convert together, each giving a 16-bit result.
// - At conversion end both channel results land in readable data registers.
// - Emitter pulses per proximity measurement programmable from 1 to 255.
// - Each emitter pulse lasts 16 us with the sink active 7.2 us.
// - Host bus runs at up to 400 kHz and the device keeps up.
// - Enabled interrupt is a level that stays until host firmware clears it.
// - Interrupt condition when a result is above upper or below lower threshold.
// - A programmable count of consecutive out-of-range results gates the interrupt.
// - Light and proximity keep separate thresholds and persistence settings.
// - Interrupt pin is open drain, active low, pulled low while pending.
// - Light and proximity interrupt sources are each maskable.
// - Programmable wait between cycles, from 2.7 ms to beyond 8 s.
// - Optional sleep state entered once an interrupt has been raised.
// - Proximity saturation status bit set when the analog path saturates.
// - Host-programmed offset is taken off proximity results.
// - Light gain and integration time are host programmable.
// - Host-selectable reduced-gain light mode for strong illumination.
//
// Design decisions made here: the register offsets and the APB register port.
`include "lps_consts.svh"

module lps_core #(
   parameter int ADDR_W = 8,
   parameter int WAIT_STEP_CYCLES = `LPS_WAIT_STEP_CYC
) (
   // System
   input wire logic i_clk,
   input wire logic i_reset,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // Converter front end, on the converter clock
   input wire logic i_conv_clk,
   input wire logic i_conv_done,
   input wire logic i_conv_is_prox,
   input wire logic [15:0] i_visible_ir_channel,
   input wire logic [15:0] i_ir_only_channel,
   input wire logic [15:0] i_conv_prox,
   input wire logic i_conv_prox_sat,
   // Converter control
   output logic o_conv_als_start,
   output logic o_conv_prox_start,
   output logic [7:0] o_als_int_steps,
   output logic [1:0] o_als_gain,
   output logic o_als_gain_low,
   // Emitter sink
   output logic o_led_sink_pin,
   // Interrupt pin
   input wire logic i_int_n_in,
   output logic o_int_n_out,
   output logic o_int_n_oe
);
   localparam logic [11:0] PULSE_LAST = 12'(`LPS_PULSE_PERIOD_CYC - 1);
   localparam logic [11:0] PULSE_ON = 12'(`LPS_PULSE_ON_CYC);
   localparam logic [31:0] WAIT_STEP_LAST = 32'(WAIT_STEP_CYCLES - 1);
   function automatic logic lps_outside(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
      return (v < lo) || (v > hi);
   endfunction : lps_outside
   function automatic logic [3:0] lps_persist_next(input logic hit, input logic [3:0] cnt);
      return hit ? ((cnt == 4'hF) ? cnt : cnt + 4'h1) : 4'h0;
   endfunction : lps_persist_next
   function automatic logic lps_persist_met(input logic [3:0] cnt, input logic [3:0] need);
      return ({1'b0, cnt} + 5'h01) >= {1'b0, need};
   endfunction : lps_persist_met
   // ---------------- Registers ----------------
   logic [`LPS_CTRL_W-1:0] ctrl;
   logic [7:0] atime;
   logic [8:0] wtime;
   logic [7:0] ppulse;
   logic [2:0] gain;
   logic [15:0] als_lo, als_hi, prox_lo, prox_hi;
   logic [3:0] als_pers, prox_pers;
   logic [15:0] poffset;
   logic [15:0] als_ch0, als_ch1, prox_data;
   logic als_valid, prox_valid, prox_sat;
   logic als_flag, prox_flag;
   logic [3:0] als_cnt, prox_cnt;
   wire power_on = ctrl[`LPS_CTRL_POWER_ON];
   wire als_en = ctrl[`LPS_CTRL_ALS_EN];
   wire prox_en = ctrl[`LPS_CTRL_PROX_EN];
   wire wait_en = ctrl[`LPS_CTRL_WAIT_EN];
   wire als_int_en = ctrl[`LPS_CTRL_ALS_INT_EN];
   wire prox_int_en = ctrl[`LPS_CTRL_PROX_INT_EN];
   wire sleep_after = ctrl[`LPS_CTRL_SLEEP_AFTER_INT];
   wire pending = als_flag || prox_flag;
   // ---------------- APB decode ----------------
   // Zero wait states: read data is registered in the setup cycle
   wire [7:0] addr = 8'(i_paddr);
   wire apb_wr = i_psel && i_penable && i_pwrite;
   wire apb_setup = i_psel && !i_penable;
   wire hit_ctrl = addr == `LPS_OFF_CTRL;
   wire hit_atime = addr == `LPS_OFF_ATIME;
   wire hit_wtime = addr == `LPS_OFF_WTIME;
   wire hit_ppulse = addr == `LPS_OFF_PPULSE;
   wire hit_gain = addr == `LPS_OFF_GAIN;
   wire hit_als_thr = addr == `LPS_OFF_ALS_THR;
   wire hit_prox_thr = addr == `LPS_OFF_PROX_THR;
   wire hit_persist = addr == `LPS_OFF_PERSIST;
   wire hit_poffset = addr == `LPS_OFF_POFFSET;
   wire hit_status = addr == `LPS_OFF_STATUS;
   wire hit_clear = addr == `LPS_OFF_CLEAR;
   wire hit_als_data = addr == `LPS_OFF_ALS_DATA;
   wire hit_prox_data = addr == `LPS_OFF_PROX_DATA;
   wire addr_ok = hit_ctrl || hit_atime || hit_wtime || hit_ppulse || hit_gain ||
                  hit_als_thr || hit_prox_thr || hit_persist || hit_poffset ||
                  hit_status || hit_clear || hit_als_data || hit_prox_data;
   wire clr_als = apb_wr && hit_clear && i_pwdata[`LPS_CLEAR_ALS];
   wire clr_prox = apb_wr && hit_clear && i_pwdata[`LPS_CLEAR_PROX];
   logic [1:0] int_pin_sync;
   lps_pkg::lps_state_e state, next_state;
   logic [31:0] read_word;
   always_comb begin
      read_word = 32'h0000_0000;
      if (hit_ctrl) read_word = {25'h0, ctrl};
      if (hit_atime) read_word = {24'h0, atime};
      if (hit_wtime) read_word = {23'h0, wtime};
      if (hit_ppulse) read_word = {24'h0, ppulse};
      if (hit_gain) read_word = {29'h0, gain};
      if (hit_als_thr) read_word = {als_hi, als_lo};
      if (hit_prox_thr) read_word = {prox_hi, prox_lo};
      if (hit_persist) read_word = {24'h0, prox_pers, als_pers};
      if (hit_poffset) read_word = {16'h0, poffset};
      if (hit_status) read_word = {21'h0, 3'(state), int_pin_sync[1], prox_sat, prox_flag,
                                   als_flag, 2'h0, prox_valid, als_valid};
      if (hit_als_data) read_word = {als_ch1, als_ch0};
      if (hit_prox_data) read_word = {16'h0, prox_data};
   end
   // Bus runs on i_clk, far above any 400 kHz host rate
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !addr_ok;
   always_ff @(posedge i_clk) begin
      if (i_reset) o_prdata <= 32'h0000_0000;
      else if (apb_setup) o_prdata <= addr_ok ? read_word : 32'h0000_0000;
   end
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctrl <= `LPS_RST_CTRL;
         atime <= `LPS_RST_ATIME;
         wtime <= {1'b0, `LPS_RST_WTIME};
         ppulse <= `LPS_RST_PPULSE;
         gain <= `LPS_RST_GAIN;
         als_lo <= `LPS_RST_THR_LO;
         als_hi <= `LPS_RST_THR_HI;
         prox_lo <= `LPS_RST_THR_LO;
         prox_hi <= `LPS_RST_THR_HI;
         als_pers <= `LPS_RST_PERSIST;
         prox_pers <= `LPS_RST_PERSIST;
         poffset <= `LPS_RST_POFFSET;
      end else if (apb_wr) begin
         if (hit_ctrl) ctrl <= i_pwdata[`LPS_CTRL_W-1:0];
         if (hit_atime) atime <= i_pwdata[7:0];
         if (hit_wtime) wtime <= i_pwdata[8:0];
         if (hit_ppulse) ppulse <= i_pwdata[7:0];
         if (hit_gain) gain <= i_pwdata[2:0];
         if (hit_als_thr) {als_hi, als_lo} <= i_pwdata;
         if (hit_prox_thr) {prox_hi, prox_lo} <= i_pwdata;
         if (hit_persist) {prox_pers, als_pers} <= i_pwdata[7:0];
         if (hit_poffset) poffset <= i_pwdata[15:0];
      end
   end

   assign o_als_int_steps = atime;
   assign o_als_gain = gain[1:0];
   assign o_als_gain_low = gain[`LPS_GAIN_LOW];
   // ---------------- Converter clock domain ----------------
   // Results are held there until the main domain acknowledges; a result
   // that completes while the previous one is still in flight is dropped.
   logic [1:0] lk_rst_sync, lk_ack_sync;
   logic lk_req;
   logic lk_is_prox, lk_sat;
   logic [15:0] lk_ch0, lk_ch1, lk_prox;
   logic [1:0] req_sync;
   logic ack;
   wire lk_rst = lk_rst_sync[1];
   wire lk_busy = lk_req != lk_ack_sync[1];
   always_ff @(posedge i_conv_clk) begin
      lk_rst_sync <= {lk_rst_sync[0], i_reset};
      lk_ack_sync <= {lk_ack_sync[0], ack};
   end
   always_ff @(posedge i_conv_clk) begin
      if (lk_rst) begin
         lk_req <= 1'b0;
      end else if (i_conv_done && !lk_busy) begin
         lk_req <= ~lk_req;
         lk_is_prox <= i_conv_is_prox;
         lk_ch0 <= i_visible_ir_channel;
         lk_ch1 <= i_ir_only_channel;
         lk_prox <= i_conv_prox;
         lk_sat <= i_conv_prox_sat;
      end
   end

   // ---------------- Result intake ----------------
   always_ff @(posedge i_clk) begin
      req_sync <= {req_sync[0], lk_req};
      int_pin_sync <= {int_pin_sync[0], i_int_n_in};
   end
   wire take = req_sync[1] != ack;
   wire take_als = take && !lk_is_prox;
   wire take_prox = take && lk_is_prox;
   wire [15:0] prox_adj = (lk_prox > poffset) ? lk_prox - poffset : 16'h0000;
   wire als_hit = lps_outside(lk_ch0, als_lo, als_hi);
   wire prox_hit = lps_outside(prox_adj, prox_lo, prox_hi);
   wire als_set = take_als && als_hit && als_int_en && lps_persist_met(als_cnt, als_pers);
   wire prox_set = take_prox && prox_hit && prox_int_en &&
                   lps_persist_met(prox_cnt, prox_pers);
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ack <= 1'b0;
         als_valid <= 1'b0;
         prox_valid <= 1'b0;
         prox_sat <= 1'b0;
         als_ch0 <= 16'h0000;
         als_ch1 <= 16'h0000;
         prox_data <= 16'h0000;
      end else if (take) begin
         ack <= ~ack;
         if (lk_is_prox) begin
            prox_data <= prox_adj;
            prox_sat <= lk_sat;
            prox_valid <= 1'b1;
         end else begin
            als_ch0 <= lk_ch0;
            als_ch1 <= lk_ch1;
            als_valid <= 1'b1;
         end
      end
   end

   // Persistence and pending flags; a new trip wins over a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         als_cnt <= 4'h0;
         prox_cnt <= 4'h0;
         als_flag <= 1'b0;
         prox_flag <= 1'b0;
      end else begin
         if (take_als) als_cnt <= lps_persist_next(als_hit, als_cnt);
         else if (clr_als) als_cnt <= 4'h0;
         if (take_prox) prox_cnt <= lps_persist_next(prox_hit, prox_cnt);
         else if (clr_prox) prox_cnt <= 4'h0;
         if (als_set) als_flag <= 1'b1;
         else if (clr_als) als_flag <= 1'b0;
         if (prox_set) prox_flag <= 1'b1;
         else if (clr_prox) prox_flag <= 1'b0;
      end
   end

   // Pin pulls low only; the board pull-up supplies the high level
   assign o_int_n_out = 1'b0;
   assign o_int_n_oe = pending;
   // ---------------- Sequencer ----------------
   logic [11:0] pulse_cyc;
   logic [7:0] pulse_num;
   logic [31:0] wait_cyc;
   logic [11:0] wait_step;
   wire [7:0] pulses_last = (ppulse == 8'h00) ? 8'h00 : ppulse - 8'h01;
   wire [11:0] wait_base = 12'h100 - {4'h0, wtime[7:0]};
   wire [11:0] wait_total = wtime[`LPS_WTIME_LONG] ?
                            12'(wait_base * `LPS_WAIT_LONG_MULT) : wait_base;
   wire pulse_end = pulse_cyc == PULSE_LAST;
   wire pulses_done = pulse_end && (pulse_num == pulses_last);
   wire wait_done = (wait_cyc == WAIT_STEP_LAST) && (wait_step == wait_total - 12'h001);
   wire [2:0] after_prox = wait_en ? 3'(lps_pkg::ST_WAIT) :
                           als_en ? 3'(lps_pkg::ST_ALS_CONV) : 3'(lps_pkg::ST_PROX_PULSE);
   wire [2:0] after_wait = als_en ? 3'(lps_pkg::ST_ALS_CONV) :
                           prox_en ? 3'(lps_pkg::ST_PROX_PULSE) : 3'(lps_pkg::ST_WAIT);
   wire [2:0] after_als = prox_en ? 3'(lps_pkg::ST_PROX_PULSE) :
                          wait_en ? 3'(lps_pkg::ST_WAIT) : 3'(lps_pkg::ST_ALS_CONV);
   wire any_meas = als_en || prox_en;
   always_comb begin
      next_state = state;
      unique case (state)
         lps_pkg::ST_IDLE: begin
            if (prox_en) next_state = lps_pkg::ST_PROX_PULSE;
            else if (als_en) next_state = lps_pkg::ST_ALS_CONV;
         end
         lps_pkg::ST_PROX_PULSE: begin
            if (pulses_done) next_state = lps_pkg::ST_PROX_CONV;
         end
         lps_pkg::ST_PROX_CONV: begin
            if (take_prox) next_state = lps_pkg::lps_state_e'(after_prox);
         end
         lps_pkg::ST_WAIT: begin
            if (wait_done) next_state = lps_pkg::lps_state_e'(after_wait);
         end
         lps_pkg::ST_ALS_CONV: begin
            if (take_als) next_state = lps_pkg::lps_state_e'(after_als);
         end
         lps_pkg::ST_SLEEP: begin
            if (!pending) next_state = lps_pkg::ST_IDLE;
         end
      endcase
      if (!power_on || !any_meas) next_state = lps_pkg::ST_IDLE;
      else if (pending && sleep_after) next_state = lps_pkg::ST_SLEEP;
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state <= lps_pkg::ST_IDLE;
         pulse_cyc <= 12'h000;
         pulse_num <= 8'h00;
         wait_cyc <= 32'h0000_0000;
         wait_step <= 12'h000;
         o_led_sink_pin <= 1'b0;
         o_conv_prox_start <= 1'b0;
         o_conv_als_start <= 1'b0;
      end else begin
         state <= next_state;
         pulse_cyc <= (state != lps_pkg::ST_PROX_PULSE || pulse_end) ? 12'h000 :
                      pulse_cyc + 12'h001;
         pulse_num <= (state != lps_pkg::ST_PROX_PULSE) ? 8'h00 :
                      pulse_end ? pulse_num + 8'h01 : pulse_num;
         wait_cyc <= (state != lps_pkg::ST_WAIT || wait_cyc == WAIT_STEP_LAST) ? 32'h0 :
                     wait_cyc + 32'h1;
         wait_step <= (state != lps_pkg::ST_WAIT) ? 12'h000 :
                      (wait_cyc == WAIT_STEP_LAST) ? wait_step + 12'h001 : wait_step;
         // Registered, so each on-phase trails its period start by one cycle
         o_led_sink_pin <= (state == lps_pkg::ST_PROX_PULSE) && (pulse_cyc < PULSE_ON);
         o_conv_prox_start <= next_state == lps_pkg::ST_PROX_CONV;
         o_conv_als_start <= next_state == lps_pkg::ST_ALS_CONV;
      end
   end
   // ---------------- Assertions ----------------
   a_data_copy: assert property (@(posedge i_clk) disable iff (i_reset)
      take_als |=> (als_ch0 == $past(lk_ch0)) && (als_ch1 == $past(lk_ch1)))
      else $error("light results not copied to data registers");
   a_pulse_count: assert property (@(posedge i_clk) disable iff (i_reset)
      (state == lps_pkg::ST_PROX_PULSE) && pulse_end |-> pulse_num <= pulses_last)
      else $error("emitter pulse count exceeds programmed value");
   // A pulse cut short by power-off or sleep is not a timing fault
   a_pulse_on_time: assert property (@(posedge i_clk) disable iff (i_reset)
      $fell(o_led_sink_pin) && ($past(state) == lps_pkg::ST_PROX_PULSE) |->
      $past(pulse_cyc) == PULSE_ON)
      else $error("emitter on-time differs from 7.2 us");
   a_int_holds: assert property (@(posedge i_clk) disable iff (i_reset)
      o_int_n_oe && !clr_als && !clr_prox |=> o_int_n_oe)
      else $error("interrupt released without a clear");
   a_int_drive: assert property (@(posedge i_clk) disable iff (i_reset)
      !o_int_n_out && (o_int_n_oe == (als_flag || prox_flag)))
      else $error("interrupt pin drive wrong");
   a_source_mask: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(als_flag) |-> $past(als_int_en) && $past(take_als) && $past(als_hit))
      else $error("masked or in-range light result raised interrupt");
   a_persist_gate: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(prox_flag) |-> ({1'b0, $past(prox_cnt)} + 5'h01) >= {1'b0, prox_pers})
      else $error("proximity interrupt before persistence met");
   a_sleep_entry: assert property (@(posedge i_clk) disable iff (i_reset)
      power_on && any_meas && pending && sleep_after |=> state == lps_pkg::ST_SLEEP)
      else $error("sleep after interrupt not entered");
   a_clear_counts: assert property (@(posedge i_clk) disable iff (i_reset)
      clr_als && !take_als |=> als_cnt == 4'h0 && !als_flag)
      else $error("clear did not reset light persistence");
   a_prox_offset: assert property (@(posedge i_clk) disable iff (i_reset)
      take_prox |=> prox_data == (($past(lk_prox) > poffset) ?
                                  $past(lk_prox) - poffset : 16'h0000))
      else $error("proximity offset not applied");
   a_idle_off: assert property (@(posedge i_clk) disable iff (i_reset)
      !power_on |=> state == lps_pkg::ST_IDLE ##1 !o_led_sink_pin)
      else $error("sequencer did not return to idle");
endmodule : lps_core

// [verif/lps_conv_model.sv]
module lps_conv_model (
   // Converter clock
   input wire logic i_conv_clk,
   // Requests from the core
   input wire logic i_als_start,
   input wire logic i_prox_start,
   // Values to return
   input wire logic [15:0] i_ch0,
   input wire logic [15:0] i_ch1,
   input wire logic [15:0] i_prox,
   input wire logic i_sat,
   // Result bus to the core
   output logic o_done,
   output logic o_is_prox,
   output logic [15:0] o_ch0,
   output logic [15:0] o_ch1,
   output logic [15:0] o_prox,
   output logic o_sat
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] als_q = 2'h0;
   logic [1:0] prox_q = 2'h0;
   int gap = 0;
   initial begin
      {o_done, o_is_prox, o_sat} = 3'h0;
      {o_ch0, o_ch1, o_prox} = 48'h0;
   end
   always @(posedge i_conv_clk) begin
      als_q <= {als_q[0], i_als_start};
      prox_q <= {prox_q[0], i_prox_start};
      o_done <= 1'b0;
      // Result lines are only meaningful with done, so keep them moving
      {o_is_prox, o_sat} <= ~{o_is_prox, o_sat};
      {o_ch0, o_ch1, o_prox} <= ~{o_ch0, o_ch1, o_prox};
      if (gap > 0) begin
         gap <= gap - 1;
      end else if (prox_q[1] || als_q[1]) begin
         o_done <= 1'b1;
         o_is_prox <= prox_q[1];
         o_ch0 <= i_ch0;
         o_ch1 <= i_ch1;
         o_prox <= i_prox;
         o_sat <= i_sat;
         // Spacing well beyond the core's acknowledge round trip
         gap <= 12;
      end
   end
endmodule : lps_conv_model

// [verif/tb_lps_core.sv]
`include "lps_consts.svh"
module tb_lps_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_conv_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic [31:0] o_prdata, q;
   logic o_pready, o_pslverr, o_conv_als_start, o_conv_prox_start, o_als_gain_low;
   logic o_led_sink_pin, o_int_n_out, o_int_n_oe, err, led_q;
   logic [7:0] o_als_int_steps;
   logic [1:0] o_als_gain;
   logic i_conv_done, i_conv_is_prox, i_conv_prox_sat;
   logic [15:0] i_visible_ir_channel, i_ir_only_channel, i_conv_prox;
   logic [15:0] m_ch0 = 16'h0050;
   logic [15:0] m_ch1 = 16'h1234;
   wire logic i_int_n_in;
   int failures = 0, checks_done = 0, n_als = 0, n_prox = 0;
   int cyc = 0, led_hi = 0, led_rise = 0, rise_gap = 0, last_rise = 0, wait_len = 0;

   // Open-drain pin with a pull-up
   assign i_int_n_in = o_int_n_oe ? o_int_n_out : 1'b1;
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      #7.3;
      forever #62.5 i_conv_clk = ~i_conv_clk;
   end
   lps_core #(.ADDR_W(8), .WAIT_STEP_CYCLES(20)) dut (.i_clk, .i_reset, .i_psel, .i_penable,
      .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_conv_clk,
      .i_conv_done, .i_conv_is_prox, .i_visible_ir_channel, .i_ir_only_channel,
      .i_conv_prox, .i_conv_prox_sat, .o_conv_als_start, .o_conv_prox_start,
      .o_als_int_steps, .o_als_gain, .o_als_gain_low, .o_led_sink_pin, .i_int_n_in,
      .o_int_n_out, .o_int_n_oe);
   lps_conv_model conv (.i_conv_clk, .i_als_start(o_conv_als_start),
      .i_prox_start(o_conv_prox_start), .i_ch0(m_ch0), .i_ch1(m_ch1), .i_prox(16'h0064),
      .i_sat(1'b1), .o_done(i_conv_done), .o_is_prox(i_conv_is_prox),
      .o_ch0(i_visible_ir_channel), .o_ch1(i_ir_only_channel), .o_prox(i_conv_prox),
      .o_sat(i_conv_prox_sat));
   always @(posedge i_conv_clk) begin
      if (i_conv_done === 1'b1 && i_conv_is_prox === 1'b1) n_prox++;
      if (i_conv_done === 1'b1 && i_conv_is_prox === 1'b0) n_als++;
   end
   always @(posedge i_clk) begin
      cyc++;
      led_q <= o_led_sink_pin;
      if (o_led_sink_pin === 1'b1) led_hi++;
      if (o_led_sink_pin === 1'b1 && led_q === 1'b0) begin
         led_rise++;
         rise_gap = cyc - last_rise;
         last_rise = cyc;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      @(posedge i_clk);
      while (o_pready !== 1'b1) @(posedge i_clk);
      q = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize

   initial begin
      repeat (40000) @(posedge i_clk);
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      summarize();
   end
   initial begin
      // Reset must also reach the converter domain through its synchroniser
      repeat (4) @(posedge i_conv_clk);
      @(posedge i_clk);
      i_reset <= 1'b0;
      rd(`LPS_OFF_CTRL, 32'h0);
      rd(`LPS_OFF_ATIME, 32'hFF);
      rd(`LPS_OFF_PPULSE, 32'h1);
      rd(`LPS_OFF_ALS_THR, 32'hFFFF0000);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `LPS_OFF_GAIN, 32'hFFFFFFFF);
      rd(`LPS_OFF_GAIN, 32'h7);
      chk({29'h0, o_als_gain_low, o_als_gain}, 32'h7);
      apb(1'b1, `LPS_OFF_ATIME, 32'hC0);
      // The write lands at the edge the task returns on
      @(posedge i_clk);
      chk({24'h0, o_als_int_steps}, 32'hC0);
      $display("registers test done");
      apb(1'b1, `LPS_OFF_PPULSE, 32'h2);
      apb(1'b1, `LPS_OFF_POFFSET, 32'h1E);
      apb(1'b1, `LPS_OFF_PROX_THR, 32'h00320000);
      led_hi = 0;
      led_rise = 0;
      apb(1'b1, `LPS_OFF_CTRL, 32'h05);
      while (o_conv_prox_start !== 1'b1) @(posedge i_clk);
      chk(32'(led_rise), 32'h2);
      chk(32'(led_hi), 32'hB40);
      chk(32'(rise_gap), 32'hC80);
      while (n_prox < 1) @(posedge i_clk);
      repeat (200) @(posedge i_clk);
      chk({31'h0, o_int_n_oe}, 32'h0);
      rd(`LPS_OFF_PROX_DATA, 32'h46);
      apb(1'b0, `LPS_OFF_STATUS, 32'h0);
      chk({31'h0, q[6]}, 32'h1);
      apb(1'b1, `LPS_OFF_CTRL, 32'h0);
      $display("proximity test done");
      apb(1'b1, `LPS_OFF_CTRL, 32'h65);
      repeat (20000) if (o_int_n_oe !== 1'b1) @(posedge i_clk);
      repeat (300) @(posedge i_clk);
      chk({30'h0, o_int_n_oe, o_int_n_out}, 32'h2);
      apb(1'b0, `LPS_OFF_STATUS, 32'h0);
      chk({26'h0, q[10:7], q[5:4]}, {26'h0, lps_pkg::ST_SLEEP, 3'h2});
      apb(1'b1, `LPS_OFF_CTRL, 32'h0);
      apb(1'b1, `LPS_OFF_CLEAR, 32'h2);
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_int_n_oe}, 32'h0);
      $display("proximity interrupt test done");
      apb(1'b1, `LPS_OFF_ALS_THR, 32'hFFFF0100);
      apb(1'b1, `LPS_OFF_PERSIST, 32'h3);
      n_als = 0;
      apb(1'b1, `LPS_OFF_CTRL, 32'h13);
      while (n_als < 2) @(posedge i_clk);
      repeat (150) @(posedge i_clk);
      chk({31'h0, o_int_n_oe}, 32'h0);
      while (n_als < 3) @(posedge i_clk);
      repeat (400) if (o_int_n_oe !== 1'b1) @(posedge i_clk);
      chk({31'h0, o_int_n_oe}, 32'h1);
      rd(`LPS_OFF_ALS_DATA, 32'h12340050);
      apb(1'b1, `LPS_OFF_CTRL, 32'h0);
      apb(1'b1, `LPS_OFF_CLEAR, 32'h1);
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_int_n_oe}, 32'h0);
      $display("light persistence test done");
      // Long wait of 2 steps: 2 x 12 steps of 20 cycles between light stages
      apb(1'b1, `LPS_OFF_WTIME, 32'h1FE);
      apb(1'b1, `LPS_OFF_CTRL, 32'h0B);
      while (o_conv_als_start !== 1'b1) @(posedge i_clk);
      while (o_conv_als_start !== 1'b0) @(posedge i_clk);
      while (o_conv_als_start !== 1'b1) begin
         @(posedge i_clk);
         wait_len++;
      end
      chk(32'(wait_len), 32'h1E0);
      apb(1'b1, `LPS_OFF_CTRL, 32'h0);
      $display("wait test done");
      summarize();
   end
endmodule : tb_lps_core
